// ===== inc/tonality_pkg.sv
// constants shared by the music tonality feature extractor
package tonality_pkg;
   localparam int E_W = 32;
   localparam int NUM_BANDS = 20;
   localparam int NUM_BINS = 128;
   // band limits
   localparam logic [4:0] BAND_HF_FIRST = 5'h0A;
   localparam logic [4:0] BAND_TOP_WB = 5'h13;
   localparam logic [4:0] BAND_TOP_NB = 5'h10;
   localparam logic [4:0] BAND_LOW_WB = 5'h00;
   localparam logic [4:0] BAND_LOW_NB = 5'h01;
   localparam logic [7:0] BIN_LAST = 8'h7F;
   localparam logic [7:0] BIN_NONE = 8'h80;
   // q16.16 values
   localparam logic [31:0] Q_ONE = 32'h0001_0000;
   localparam logic [31:0] ALT_LT_INIT = 32'h0000_07AE;
   localparam logic [31:0] DIV_LIMIT = 32'h0005_0000;
   localparam logic [63:0] HF_MIN = 64'h0000_0000_0064_0000;
   localparam logic [31:0] HF_CAP = 32'h0009_FFFF;
   localparam logic [31:0] THR_INIT = 32'h0038_0000;
   localparam logic [31:0] MSUM_FIX = 32'h0038_0000;
   localparam logic [31:0] THR_STEP = 32'h0000_3333;
   localparam logic [31:0] THR_MAX = 32'h003C_0000;
   localparam logic [31:0] THR_MIN = 32'h0031_0000;
   // q0.16 coefficients
   localparam logic [15:0] ALPHA_BASE = 16'hC000;
   localparam logic [15:0] ALPHA_SLOPE = 16'h1062;
   localparam logic [15:0] ALPHA_MAX = 16'hFFBE;
   localparam logic [15:0] ACT_KEEP = 16'hFD71;
   localparam logic [15:0] ACT_STEP = 16'h028F;
   localparam logic [15:0] LT_KEEP = 16'hE666;
   localparam logic [15:0] LT_GAIN = 16'h199A;
   localparam logic [15:0] STRONG_LIM = 16'hF333;
   // q8.8 scale factors
   localparam logic [15:0] DB_SCALE = 16'h0303;
   localparam logic [15:0] NB_SCALE = 16'h0188;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DIV = 8'h08;
   localparam logic [7:0] REG_COMPLEMENTARY_NONSTATIONARITY = 8'h0C;
   localparam logic [7:0] REG_ACT = 8'h10;
   localparam logic [7:0] REG_HF = 8'h14;
   localparam logic [7:0] REG_HF_LT = 8'h18;
   localparam logic [7:0] REG_MSUM = 8'h1C;
   localparam logic [7:0] REG_THR = 8'h20;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   typedef enum logic [3:0] {
      ST_IDLE, ST_BAND1, ST_RATIO, ST_BAND2, ST_BINLOG,
      ST_SEGFIND, ST_SEGRES, ST_SEGMAP, ST_FINISH
   } state_t;
endpackage : tonality_pkg

// ===== hw/music_tonality_feature_extractor.sv
// per-frame music and tonality feature extractor with an ahb-lite register slave
// Behaviour
// RULE1: bands 10 to top band: take max and min of current and two-frames-old energies
// RULE2: spectral diversity is max-weighted ratio sum over sum of maxima
// RULE3: alternative long-term band energy starts 0.03, factor forced 0 above diversity 5
// RULE4: complementary non-stationarity is product of (max+1)/(min+1) per band
// RULE5: activity average 0.99 old plus 0.01 on activity or tonality, within 0..1
// RULE6: high/low band energy ratio capped below 10, zero unless both sums exceed 100
// RULE7: long-term hf ratio is 0.9 old plus 0.1 current, reset to zero
// RULE8: log spectrum is 10 log10 of mean bin energy, bins 0..127
// RULE9: minima are bins below both neighbours, plus edge bins below their neighbour
// RULE10: floor interpolates between minima, equals spectrum outside the span
// RULE11: residual is spectrum minus floor, kept as next frame's previous residual
// RULE12: per peak normalised squared correlation, zero outside the minima span
// RULE13: long-term map is 0.9 old plus 0.1 current, starts at zero
// RULE14: strong-peak flag set when any long-term bin exceeds 0.95
// RULE15: sum all long-term bins, scale by 1.53 for narrowband
// RULE16: threshold starts 56, steps down 0.2 if sum exceeds 56, else up
// RULE17: threshold stays within 49 and 60
// RULE18: tonal flag when sum exceeds threshold or strong-peak flag set
// RULE19: update factor is 0.064 times clipped relative energy plus 0.75, max 0.999
// RULE20: lowest band is 0 for wideband, 1 for narrowband
// RULE21: upstream holds threshold, bandwidth and relative energy stable during a frame
// RULE22: frame start pulse begins work, one-cycle done pulse ends it
// RULE23: two-frame band history and previous residual kept; reset restores all state
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module music_tonality_feature_extractor (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic frame_start,
   input wire logic band_narrow,
   input wire logic [tonality_pkg::E_W-1:0] stationarity_threshold,
   input wire logic [tonality_pkg::E_W-1:0] nonstat_level,
   input wire logic [15:0] rel_energy,
   output logic [6:0] fetch_index,
   input wire logic [tonality_pkg::E_W-1:0] band_energy_first,
   input wire logic [tonality_pkg::E_W-1:0] band_energy_second,
   input wire logic [tonality_pkg::E_W-1:0] bin_energy_first,
   input wire logic [tonality_pkg::E_W-1:0] bin_energy_second,
   output logic frame_done,
   output logic [31:0] spectral_diversity,
   output logic [31:0] complementary_nonstationarity,
   output logic [15:0] activity_average,
   output logic [31:0] hf_energy_ratio,
   output logic [31:0] hf_energy_longterm,
   output logic tonal_flag
);
   import tonality_pkg::*;

   function automatic logic signed [15:0] to_db(input logic [31:0] x);
      logic [4:0] p;
      logic [31:0] n;
      logic signed [7:0] ip;
      logic signed [15:0] l2;
      logic signed [31:0] prod;
      p = 5'h00;
      for (int k = 0; k < 32; k++) begin
         if (x[k]) p = 5'(k);
      end
      n = x << (5'h1F - p);
      ip = $signed({3'h0, p}) - 8'sh10;
      l2 = {ip, n[30:23]};
      prod = l2 * $signed({1'b0, DB_SCALE});
      return prod[23:8];
   endfunction : to_db

   function automatic logic [7:0] next_min(input logic [127:0] m, input logic [7:0] from);
      logic [7:0] r;
      r = BIN_NONE;
      for (int k = 127; k >= 0; k--) begin
         if (m[k] && (8'(k) > from)) r = 8'(k);
      end
      return r;
   endfunction : next_min

   ////////////////////////////////////////////////////////////////////////////
   state_t state_reg;
   logic [7:0] idx_reg, lo_reg, hi_reg;
   logic real_reg, enable_reg, clear_reg, init, strong_reg, tonal_reg, done_reg;
   logic [31:0] hist_a_reg [NUM_BANDS];
   logic [31:0] hist_b_reg [NUM_BANDS];
   logic [31:0] alt_lt_reg [NUM_BANDS];
   logic signed [15:0] spec_reg [NUM_BINS];
   logic signed [15:0] cur_res_reg [NUM_BINS];
   logic signed [15:0] prev_res_reg [NUM_BINS];
   logic [15:0] map_lt_reg [NUM_BINS];
   logic [63:0] div_num_reg, div_den_reg, hf_hi_reg, hf_lo_reg;
   logic [31:0] pdiv_reg, ns2_reg, hf_reg, hf_lt_reg, msum_reg, thr_reg;
   logic [15:0] act_reg, frames_reg;
   logic signed [63:0] cross_reg;
   logic [63:0] ecur_reg, eprev_reg;
   logic [4:0] band_lo, band_hi, bi;
   logic [127:0] is_min;
   logic [7:0] min_count;

   assign init = reset | clear_reg;
   assign band_lo = band_narrow ? BAND_LOW_NB : BAND_LOW_WB; // RULE20
   assign band_hi = band_narrow ? BAND_TOP_NB : BAND_TOP_WB; // RULE1
   assign bi = idx_reg[4:0];

   // accumulators restart on an accepted strobe, so the features hold while idle
   logic frame_go;
   assign frame_go = (state_reg == ST_IDLE) && frame_start && enable_reg;

   // band arithmetic
   logic [31:0] b_mean, emax, emin, fmax, fmin, ratio, beta;
   logic [63:0] ns2_prod, alt_mix, alpha_wide;
   logic [15:0] rel_pos;
   always_comb begin
      b_mean = 32'(({1'b0, band_energy_first} + {1'b0, band_energy_second}) >> 1);
      emax = (band_energy_first > hist_b_reg[bi]) ? band_energy_first : hist_b_reg[bi]; // RULE1
      emin = (band_energy_first > hist_b_reg[bi]) ? hist_b_reg[bi] : band_energy_first; // RULE1
      fmax = (b_mean > alt_lt_reg[bi]) ? b_mean : alt_lt_reg[bi];
      fmin = (b_mean > alt_lt_reg[bi]) ? alt_lt_reg[bi] : b_mean;
      ratio = 32'(({32'h0, fmax + Q_ONE} << 16) / {32'h0, fmin + Q_ONE}); // RULE4
      ns2_prod = ({32'h0, ns2_reg} * {32'h0, ratio}) >> 16;
      rel_pos = rel_energy[15] ? 16'h0000 : rel_energy; // RULE19
      alpha_wide = {48'h0, ALPHA_BASE} + ((64'(rel_pos) * {48'h0, ALPHA_SLOPE}) >> 8);
      beta = (alpha_wide > {48'h0, ALPHA_MAX}) ? {16'h0, ALPHA_MAX} : alpha_wide[31:0];
      if (pdiv_reg > DIV_LIMIT) beta = 32'h0; // RULE3
      alt_mix = ({32'h0, alt_lt_reg[bi]} * {32'h0, beta}
                 + {32'h0, b_mean} * {32'h0, Q_ONE - beta}) >> 16; // RULE3
   end

   // minima search over the whole log spectrum
   for (genvar g = 0; g < NUM_BINS; g++) begin : g_min
      if (g == 0) begin : g_first
         assign is_min[g] = spec_reg[0] < spec_reg[1]; // RULE9
      end else if (g == NUM_BINS - 1) begin : g_last
         assign is_min[g] = spec_reg[g] < spec_reg[g-1]; // RULE9
      end else begin : g_mid
         assign is_min[g] = (spec_reg[g] < spec_reg[g-1]) && (spec_reg[g] < spec_reg[g+1]); // RULE9
      end
   end
   always_comb begin
      min_count = 8'h00;
      for (int k = 0; k < NUM_BINS; k++) begin
         min_count = min_count + {7'h0, is_min[k]};
      end
   end

   // floor, residual and correlation per bin
   logic [7:0] jj;
   logic signed [16:0] dspec;
   logic signed [25:0] interp;
   logic signed [15:0] floor_v, res_now;
   logic signed [23:0] cx;
   logic [23:0] cx_abs;
   logic [63:0] corr_num, corr_den, corr_q;
   logic [15:0] corr, map_new;
   always_comb begin
      jj = idx_reg;
      dspec = 17'(spec_reg[hi_reg[6:0]]) - 17'(spec_reg[lo_reg[6:0]]);
      interp = (26'(dspec) * $signed({18'h0, jj - lo_reg})) / $signed({18'h0, hi_reg - lo_reg});
      floor_v = spec_reg[lo_reg[6:0]] + interp[15:0]; // RULE10
      res_now = real_reg ? (spec_reg[jj[6:0]] - floor_v) : 16'sh0000; // RULE10 RULE11
      cx = cross_reg[37:14];
      cx_abs = cx[23] ? 24'(-cx) : cx;
      corr_num = {24'h0, cx_abs} * {40'h0, cx_abs} << 16;
      corr_den = {40'h0, ecur_reg[37:14]} * {40'h0, eprev_reg[37:14]};
      corr_q = (corr_den == 64'h0) ? 64'h0 : corr_num / corr_den; // RULE12
      corr = !real_reg ? 16'h0000 : (corr_q > 64'hFFFF) ? 16'hFFFF : corr_q[15:0]; // RULE12
      map_new = 16'(({16'h0, map_lt_reg[jj[6:0]]} * {16'h0, LT_KEEP}
                     + {16'h0, corr} * {16'h0, LT_GAIN}) >> 16); // RULE13
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer
   logic seg_end;
   assign seg_end = (idx_reg + 8'h01) == hi_reg;
   always_ff @(posedge ref_clk) begin
      if (init) begin
         state_reg <= ST_IDLE;
         idx_reg <= 8'h00;
         lo_reg <= 8'h00;
         hi_reg <= 8'h00;
         real_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (frame_start && enable_reg) begin // RULE22
                  state_reg <= ST_BAND1;
                  idx_reg <= {3'h0, band_lo};
               end
            end
            ST_BAND1: begin
               idx_reg <= idx_reg + 8'h01;
               if (bi == band_hi) state_reg <= ST_RATIO;
            end
            ST_RATIO: begin
               state_reg <= ST_BAND2;
               idx_reg <= {3'h0, band_lo};
            end
            ST_BAND2: begin
               idx_reg <= idx_reg + 8'h01;
               if (bi == band_hi) begin
                  state_reg <= ST_BINLOG;
                  idx_reg <= 8'h00;
               end
            end
            ST_BINLOG: begin
               idx_reg <= idx_reg + 8'h01;
               if (idx_reg == BIN_LAST) begin
                  state_reg <= ST_SEGFIND;
                  lo_reg <= 8'h00;
               end
            end
            ST_SEGFIND: begin
               hi_reg <= next_min(is_min, lo_reg);
               real_reg <= is_min[lo_reg[6:0]] && (next_min(is_min, lo_reg) != BIN_NONE); // RULE10
               idx_reg <= lo_reg;
               state_reg <= ST_SEGRES;
            end
            ST_SEGRES: begin
               idx_reg <= seg_end ? lo_reg : idx_reg + 8'h01;
               if (seg_end) state_reg <= ST_SEGMAP;
            end
            ST_SEGMAP: begin
               idx_reg <= idx_reg + 8'h01;
               if (seg_end) begin
                  lo_reg <= hi_reg;
                  state_reg <= (hi_reg == BIN_NONE) ? ST_FINISH : ST_SEGFIND;
               end
            end
            ST_FINISH: state_reg <= ST_IDLE;
         endcase
      end
   end
   assign fetch_index = idx_reg[6:0];

   // band state: history and alternative long-term energy
   always_ff @(posedge ref_clk) begin
      if (init) begin
         for (int b = 0; b < NUM_BANDS; b++) begin
            hist_a_reg[b] <= 32'h0; // RULE23
            hist_b_reg[b] <= 32'h0;
            alt_lt_reg[b] <= ALT_LT_INIT; // RULE3
         end
      end else if (state_reg == ST_BAND2) begin
         hist_b_reg[bi] <= hist_a_reg[bi]; // RULE23
         hist_a_reg[bi] <= band_energy_second;
         alt_lt_reg[bi] <= alt_mix[31:0]; // RULE3
      end
   end

   // band accumulators and ratios
   always_ff @(posedge ref_clk) begin
      if (init || frame_go) begin
         div_num_reg <= 64'h0;
         div_den_reg <= 64'h0;
         hf_hi_reg <= 64'h0;
         hf_lo_reg <= 64'h0;
         ns2_reg <= Q_ONE;
      end else if (state_reg == ST_BAND1) begin
         ns2_reg <= (ns2_prod > 64'hFFFF_FFFF) ? 32'hFFFF_FFFF : ns2_prod[31:0]; // RULE4
         if (bi >= BAND_HF_FIRST) begin
            div_num_reg <= div_num_reg + ({32'h0, emax} * {32'h0, emax})
                           / {32'h0, (emin == 32'h0) ? 32'h1 : emin}; // RULE2
            div_den_reg <= div_den_reg + {32'h0, emax}; // RULE2
            hf_hi_reg <= hf_hi_reg + {32'h0, b_mean}; // RULE6
         end else begin
            hf_lo_reg <= hf_lo_reg + {32'h0, b_mean}; // RULE6
         end
      end
   end

   logic [63:0] pdiv_q, hf_q;
   always_comb begin
      pdiv_q = (div_den_reg == 64'h0) ? 64'h0 : (div_num_reg << 16) / div_den_reg; // RULE2
      hf_q = (hf_lo_reg == 64'h0) ? 64'h0 : (hf_hi_reg << 16) / hf_lo_reg;
   end
   always_ff @(posedge ref_clk) begin
      if (init) begin
         pdiv_reg <= 32'h0;
         hf_reg <= 32'h0;
      end else if (state_reg == ST_RATIO) begin
         pdiv_reg <= (pdiv_q > 64'hFFFF_FFFF) ? 32'hFFFF_FFFF : pdiv_q[31:0];
         if ((hf_hi_reg > HF_MIN) && (hf_lo_reg > HF_MIN)) begin // RULE6
            hf_reg <= (hf_q > {32'h0, HF_CAP}) ? HF_CAP : hf_q[31:0]; // RULE6
         end else begin
            hf_reg <= 32'h0; // RULE6
         end
      end
   end

   // spectrum arrays; the previous residual is only replaced after its peak is correlated
   always_ff @(posedge ref_clk) begin
      if (init) begin
         for (int k = 0; k < NUM_BINS; k++) begin
            spec_reg[k] <= 16'sh0000;
            cur_res_reg[k] <= 16'sh0000;
            prev_res_reg[k] <= 16'sh0000; // RULE23
            map_lt_reg[k] <= 16'h0000; // RULE13
         end
      end else begin
         if (state_reg == ST_BINLOG) begin
            spec_reg[jj[6:0]] <= to_db(32'(({1'b0, bin_energy_first}
                                 + {1'b0, bin_energy_second}) >> 1)); // RULE8
         end
         if (state_reg == ST_SEGRES) cur_res_reg[jj[6:0]] <= res_now; // RULE11
         if (state_reg == ST_SEGMAP) begin
            prev_res_reg[jj[6:0]] <= cur_res_reg[jj[6:0]]; // RULE11
            map_lt_reg[jj[6:0]] <= map_new; // RULE13
         end
      end
   end

   // peak correlation sums, cleared for every segment
   always_ff @(posedge ref_clk) begin
      if (init || (state_reg == ST_SEGFIND)) begin
         cross_reg <= 64'sh0;
         ecur_reg <= 64'h0;
         eprev_reg <= 64'h0;
      end else if (state_reg == ST_SEGRES) begin
         cross_reg <= cross_reg + 64'(res_now * prev_res_reg[jj[6:0]]); // RULE12
         ecur_reg <= ecur_reg + 64'(res_now * res_now);
         eprev_reg <= eprev_reg + 64'(prev_res_reg[jj[6:0]] * prev_res_reg[jj[6:0]]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame decision
   logic [63:0] msum_eff;
   logic [31:0] thr_step, thr_new;
   logic tonal_new, act_cond;
   logic [31:0] act_mix, hf_lt_mix;
   always_comb begin
      msum_eff = band_narrow ? (({32'h0, msum_reg} * {48'h0, NB_SCALE}) >> 8) // RULE15
                             : {32'h0, msum_reg};
      thr_step = (msum_eff > {32'h0, MSUM_FIX}) ? thr_reg - THR_STEP : thr_reg + THR_STEP; // RULE16
      thr_new = (thr_step > THR_MAX) ? THR_MAX : (thr_step < THR_MIN) ? THR_MIN : thr_step; // RULE17
      tonal_new = (msum_eff > {32'h0, thr_new}) || strong_reg; // RULE18
      act_cond = (nonstat_level > stationarity_threshold) || tonal_new; // RULE5
      act_mix = (({16'h0, act_reg} * {16'h0, ACT_KEEP}) >> 16)
                + (act_cond ? {16'h0, ACT_STEP} : 32'h0); // RULE5
      hf_lt_mix = 32'(({32'h0, hf_lt_reg} * {48'h0, LT_KEEP}
                       + {32'h0, hf_reg} * {48'h0, LT_GAIN}) >> 16); // RULE7
   end

   always_ff @(posedge ref_clk) begin
      if (init || frame_go) begin
         msum_reg <= 32'h0;
         strong_reg <= 1'b0;
      end else if (state_reg == ST_SEGMAP) begin
         msum_reg <= msum_reg + {16'h0, map_new}; // RULE15
         if (map_new > STRONG_LIM) strong_reg <= 1'b1; // RULE14
      end
   end

   always_ff @(posedge ref_clk) begin
      if (init) begin
         thr_reg <= THR_INIT; // RULE16
         tonal_reg <= 1'b0;
         act_reg <= 16'h0000;
         hf_lt_reg <= 32'h0; // RULE7
         done_reg <= 1'b0;
         frames_reg <= 16'h0000;
      end else begin
         done_reg <= state_reg == ST_FINISH; // RULE22
         if (state_reg == ST_FINISH) begin
            thr_reg <= thr_new; // RULE16
            tonal_reg <= tonal_new; // RULE18
            act_reg <= (act_mix > 32'hFFFF) ? 16'hFFFF : act_mix[15:0]; // RULE5
            hf_lt_reg <= hf_lt_mix; // RULE7
            frames_reg <= frames_reg + 16'h0001;
         end
      end
   end

   assign frame_done = done_reg;
   assign spectral_diversity = pdiv_reg;
   assign complementary_nonstationarity = ns2_reg;
   assign activity_average = act_reg;
   assign hf_energy_ratio = hf_reg;
   assign hf_energy_longterm = hf_lt_reg;
   assign tonal_flag = tonal_reg;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states; clear aborts a frame in flight
   logic ap_valid, ap_write;
   logic [7:0] ap_addr;
   logic [31:0] rd_mux;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         ap_valid <= hsel && hready && htrans[1];
         ap_write <= hwrite;
         ap_addr <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite) hrdata <= rd_mux;
      end
   end
   always_comb begin
      unique case (haddr[7:0])
         REG_CTRL: rd_mux = {31'h0, enable_reg};
         REG_STATUS: rd_mux = {frames_reg, min_count, 5'h00, strong_reg, tonal_reg,
                               state_reg != ST_IDLE};
         REG_DIV: rd_mux = pdiv_reg;
         REG_COMPLEMENTARY_NONSTATIONARITY: rd_mux = ns2_reg;
         REG_ACT: rd_mux = {16'h0, act_reg};
         REG_HF: rd_mux = hf_reg;
         REG_HF_LT: rd_mux = hf_lt_reg;
         REG_MSUM: rd_mux = msum_reg;
         REG_THR: rd_mux = thr_reg;
         default: rd_mux = 32'h0;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         {clear_reg, enable_reg} <= CTRL_RESET;
      end else begin
         clear_reg <= 1'b0;
         if (ap_valid && ap_write && (ap_addr == REG_CTRL)) begin
            enable_reg <= hwdata[0];
            clear_reg <= hwdata[1];
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (init);

   a_done_pulse_once: assert property (frame_done |=> !frame_done) // RULE22
      else $error("done pulse longer than one cycle");
   a_frame_bounded: assert property (state_reg == ST_IDLE && frame_start && enable_reg
      |-> ##[400:700] frame_done) // RULE22
      else $error("frame did not finish in time");
   a_thr_limits: assert property (thr_reg <= THR_MAX && thr_reg >= THR_MIN) // RULE17
      else $error("tonal threshold out of range");
   a_thr_moves_step: assert property (frame_done |-> thr_reg == $past(thr_reg, 2)
      || thr_reg == THR_MAX || thr_reg == THR_MIN
      || thr_reg == $past(thr_reg, 2) + THR_STEP || thr_reg == $past(thr_reg, 2) - THR_STEP) // RULE16
      else $error("tonal threshold moved by a wrong amount");
   a_tonal_strong: assert property (state_reg == ST_FINISH && strong_reg |=> tonal_flag) // RULE18
      else $error("strong peak without tonal flag");
   a_hf_capped: assert property (hf_energy_ratio <= HF_CAP) // RULE6
      else $error("hf ratio reached ten");
   a_hf_gate: assert property (state_reg == ST_RATIO && hf_lo_reg <= HF_MIN
      |=> hf_energy_ratio == 32'h0) // RULE6
      else $error("hf ratio set on low energy");
   a_band_range: assert property (state_reg == ST_BAND1 |-> bi >= band_lo && bi <= band_hi) // RULE1
      else $error("band index out of range");
   a_res_outside: assert property (state_reg == ST_SEGRES && !real_reg |=>
      cur_res_reg[$past(jj[6:0])] == 16'sh0000) // RULE10
      else $error("residual nonzero outside span");
   a_act_decay: assert property (state_reg == ST_FINISH && !act_cond && act_reg != 16'h0
      |=> act_reg < $past(act_reg)) // RULE5
      else $error("activity average did not decay");

   c_tonal_frame: cover property (frame_done && tonal_flag);
   c_narrow_frame: cover property (frame_done && band_narrow);
   c_diverse_frame: cover property (state_reg == ST_BAND2 && pdiv_reg > DIV_LIMIT);
   c_real_peak: cover property (state_reg == ST_SEGMAP && real_reg && corr != 16'h0);
endmodule : music_tonality_feature_extractor

// ===== verif/energy_source.sv
// upstream model: energies offered for the index the block fetches
`timescale 1ns/10ps
module energy_source (
   input wire logic [6:0] fetch_index,
   input wire logic peaky,
   input wire logic [31:0] level,
   output logic [31:0] band_first,
   output logic [31:0] band_second,
   output logic [31:0] bin_first,
   output logic [31:0] bin_second
);
   // flat unless peaky: odd bins four times higher put a minimum at every even bin
   assign band_first = (fetch_index < 7'h14) ? level : 32'h0000_0000;
   assign band_second = band_first;
   assign bin_first = (peaky && fetch_index[0]) ? {level[29:0], 2'h0} : level;
   assign bin_second = bin_first;
endmodule : energy_source

// ===== verif/tb_music_tonality_feature_extractor.sv
// bench: bus reads, flat and peaky frames against the feature outputs
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_music_tonality_feature_extractor;
   import tonality_pkg::*;
   logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, fs = 0, nb = 0, hrdy, hresp, done, tonal;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, thr = 0, nsl = 0, lvl = 0, q;
   logic [31:0] bf, bs, nf, ns, div, cns, hf, hflt;
   logic [1:0] htrans = 0;
   logic [6:0] fi;
   logic [15:0] act, rel = 16'h0100;
   logic pk = 0;
   int mismatches = 0, n_tests = 0;
   music_tonality_feature_extractor u_music_tonality_feature_extractor (.ref_clk(ref_clk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
      .hresp(hresp), .frame_start(fs), .band_narrow(nb), .stationarity_threshold(thr),
      .nonstat_level(nsl), .rel_energy(rel), .fetch_index(fi), .band_energy_first(bf),
      .band_energy_second(bs), .bin_energy_first(nf), .bin_energy_second(ns),
      .frame_done(done), .spectral_diversity(div), .complementary_nonstationarity(cns),
      .activity_average(act), .hf_energy_ratio(hf), .hf_energy_longterm(hflt),
      .tonal_flag(tonal));
   energy_source u_energy_source (.fetch_index(fi), .peaky(pk), .level(lvl), .band_first(bf),
      .band_second(bs), .bin_first(nf), .bin_second(ns));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : xfer
   // inputs stay put from the strobe until the done pulse
   task frame(input logic [31:0] l);
      lvl <= l;
      @(posedge ref_clk);
      fs <= 1'b1;
      @(posedge ref_clk);
      fs <= 1'b0;
      repeat (2000) begin
         @(posedge ref_clk);
         if (done === 1'b1) break;
      end
      `CHK("done", 1'b1, done)
   endtask : frame
   task test_done;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #480000;
      mismatches++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      xfer(0, REG_THR, 0);
      `CHK("thr", THR_INIT, q)
      `CHK("resp", 1'b0, hresp)
      xfer(0, REG_COMPLEMENTARY_NONSTATIONARITY, 0);
      `CHK("ns2", Q_ONE, q)
      xfer(0, 8'hFC, 0);
      `CHK("unmapped", 32'h0000_0000, q)
      $display("test reset done");
      nsl <= 32'h0000_0001;
      frame(Q_ONE);
      `CHK("act", ACT_STEP, act)
      `CHK("hf low", 32'h0000_0000, hf)
      `CHK("tonal", 1'b0, tonal)
      xfer(0, REG_THR, 0);
      `CHK("thr up", THR_INIT + THR_STEP, q)
      `CHK("ns2 sat", 32'hFFFF_FFFF, cns)
      $display("test first frame done");
      nsl <= 32'h0000_0000;
      thr <= 32'h0000_0001;
      frame(32'h0010_0000);
      `CHK("hf lt", {16'h0, LT_GAIN}, hflt)
      repeat (20) frame(32'h0010_0000);
      `CHK("div", Q_ONE, div)
      `CHK("hf", Q_ONE, hf)
      `CHK("ns2 flat", Q_ONE, cns)
      xfer(0, REG_THR, 0);
      `CHK("thr max", THR_MAX, q)
      nb <= 1'b1;
      frame(32'h0010_0000);
      `CHK("hf nb", 32'h0000_C71C, hf)
      nb <= 1'b0;
      $display("test flat frames done");
      xfer(1, REG_CTRL, 32'h0000_0003);
      xfer(0, REG_THR, 0);
      `CHK("thr clr", THR_INIT, q)
      xfer(0, REG_HF_LT, 0);
      `CHK("hf lt clr", 32'h0000_0000, q)
      $display("test soft reset done");
      pk <= 1'b1;
      rel <= 16'hFF00;
      repeat (32) frame(32'h0010_0000);
      `CHK("tonal on", 1'b1, tonal)
      xfer(0, REG_STATUS, 0);
      `CHK("status", 32'h0020_4006, q)
      $display("test peaky frames done");
      test_done();
   end
endmodule : tb_music_tonality_feature_extractor
